// *** logic/rtcpw_pkg.sv ***
// Purpose: Constants for the clock power-control configuration block.
// Assumes: Avalon-MM slave with 32-bit data and 16-bit registers in the low lanes.
// Notes:   All offsets are byte addresses of aligned words.
package rtcpw_pkg;
    // =========================================================================
    // Register map
    localparam logic [3:0]  RTCPW_OFS_CALCFG  = 4'h0;
    localparam logic [3:0]  RTCPW_OFS_PWCFG   = 4'h4;
    localparam logic [3:0]  RTCPW_OFS_MINSECV = 4'h8;
    localparam logic [15:0] RTCPW_RST_VAL     = 16'h0000;
    localparam logic [15:0] RTCPW_PWC_MASK    = 16'hFF00;
    // =========================================================================
    // Field positions
    localparam int RTCPW_B_ENABLE  = 15;
    localparam int RTCPW_B_WREN    = 13;
    localparam int RTCPW_B_HALF_SECOND_STATUS = 11;
    localparam int RTCPW_B_POWER_CTRL_ENABLE   = 15;
    localparam int RTCPW_B_POWER_CTRL_POLARITY  = 14;
    localparam int RTCPW_B_CPRE    = 13;
    localparam int RTCPW_B_SPRE    = 12;
    localparam int RTCPW_B_CLK     = 10;
    localparam int RTCPW_B_OUT     = 8;
    localparam int RTCPW_B_SPARE_A = 14;
    localparam int RTCPW_B_SPARE_B = 12;
    localparam int RTCPW_B_SPARE_C = 8;
    localparam int RTCPW_W_SPARE_C = 3;
    localparam int RTCPW_W_BYTE    = 8;
    localparam int RTCPW_W_SEL     = 2;
    localparam int RTCPW_W_REG     = 16;
    // =========================================================================
    // Encodings
    typedef enum logic [1:0] {
        RTCPW_CLK_SECONDARY = 2'h0,
        RTCPW_CLK_LOW_POWER_RC_OSC      = 2'h1,
        RTCPW_CLK_LINE_A    = 2'h2,
        RTCPW_CLK_LINE_B    = 2'h3
    } rtcpw_clk_t;
    localparam logic [1:0] RTCPW_OUT_ALARM = 2'h0;
    localparam logic [1:0] RTCPW_OUT_SECS  = 2'h1;
    localparam logic [1:0] RTCPW_OUT_PWC   = 2'h3;
    typedef enum logic [2:0] {
        RTCPW_ST_IDLE = 3'h1,
        RTCPW_ST_ACK  = 3'h2,
        RTCPW_ST_DONE = 3'h4
    } rtcpw_state_t;
endpackage : rtcpw_pkg

// *** logic/rtcpw_window.sv ***
// Purpose: Windowed tick generator with a one-bit divide-by-two prescaler.
// Assumes: Tick input is a one-cycle pulse from the selected timekeeping clock.
// Notes:   Restart clears the divider phase.
`timescale 1ns/1ps
module rtcpw_window
    import rtcpw_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic clk_en,
    input  wire logic tick_in,
    input  wire logic div2,
    input  wire logic restart,
    output logic      tick_out
);
    logic phase_reg;
    logic phase_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        phase_next = phase_reg;
        tick_next  = 1'b0;
        if (restart) begin
            phase_next = 1'b0;
        end else if (tick_in) begin
            // Divide by two when set, pass every tick when clear.
            phase_next = div2 ? ~phase_reg : 1'b0;
            tick_next  = div2 ? phase_reg : 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= 1'b0;
            tick_reg  <= 1'b0;
        end else if (clk_en) begin
            phase_reg <= phase_next;
            tick_reg  <= tick_next;
        end
    end

    assign tick_out = tick_reg;
endmodule : rtcpw_window

// *** logic/rtcpw_ctrl.sv ***
// Purpose: Power-control configuration and clock/output selection of the clock unit.
// Assumes: nrst is the power-on reset; other resets never reach this block.
// Notes:   Avalon-MM slave; waitrequest drops for one cycle, one edge after the edge where a request is seen.
`timescale 1ns/1ps
module rtcpw_ctrl
    import rtcpw_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        secondary_osc_tick,
    input  wire logic        low_power_rc_osc_tick,
    input  wire logic        line_tick,
    input  wire logic        half_second_in,
    input  wire logic        alarm_pulse,
    input  wire logic        seconds_clock,
    input  wire logic        power_ctrl_raw,
    output logic             timekeeping_tick,
    output logic             prescaler_reset,
    output logic             clock_module_enable,
    output logic             half_second_status,
    output logic             stability_tick,
    output logic             sample_tick,
    output logic             power_ctrl_active,
    output logic             clock_out_pin
);
    // =========================================================================
    // Bus handshake
    rtcpw_state_t state_reg;
    rtcpw_state_t state_next;
    logic [31:0]  rdata_reg;
    logic [31:0]  rdata_next;
    logic [15:0]  calcfg_reg;
    logic [15:0]  calcfg_next;
    logic [15:0]  pwcfg_reg;
    logic [15:0]  pwcfg_next;
    logic         presc_rst_reg;
    logic         presc_rst_next;
    logic         tick_reg;
    logic         tick_next;
    logic         pin_reg;
    logic         pin_next;
    logic         pwact_reg;
    logic         pwact_next;
    logic         take_wr;
    logic         pwc_out;

    // A write lands at the one edge where waitrequest is sampled low, so a held request
    // is applied exactly once and never ahead of the master seeing its answer.
    assign take_wr = (state_reg == RTCPW_ST_DONE) && avs_write;

    // =========================================================================
    // Write decode
    logic wr_calcfg;
    logic wr_pwcfg;
    logic wr_minutes_seconds_value;

    // Each register listens only to the lanes that hold its bits.
    assign wr_calcfg = take_wr && (avs_address == RTCPW_OFS_CALCFG);
    assign wr_pwcfg  = take_wr && (avs_address == RTCPW_OFS_PWCFG) && avs_byteenable[1];
    assign wr_minutes_seconds_value = take_wr && (avs_address == RTCPW_OFS_MINSECV) && avs_byteenable[0];

    // =========================================================================
    // Read mux
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        case (avs_address)
            RTCPW_OFS_CALCFG: rd_word = {16'h0000, calcfg_reg};
            RTCPW_OFS_PWCFG:  rd_word = {16'h0000, pwcfg_reg};
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        rdata_next = rdata_reg;
        case (state_reg)
            RTCPW_ST_IDLE: begin
                if (avs_read || avs_write) begin
                    state_next = RTCPW_ST_ACK;
                end
            end
            RTCPW_ST_ACK: begin
                state_next = RTCPW_ST_DONE;
                rdata_next = 32'h0000_0000;
                if (avs_read) begin
                    rdata_next = rd_word;
                end
            end
            RTCPW_ST_DONE: begin
                state_next = RTCPW_ST_IDLE;
            end
            default: begin
                state_next = RTCPW_ST_IDLE;
            end
        endcase
    end

    // =========================================================================
    // Registers
    always_comb begin
        calcfg_next    = calcfg_reg;
        pwcfg_next     = pwcfg_reg;
        presc_rst_next = 1'b0;
        // The half-second flag is hardware-owned; config writes never land on it, but a low-byte seconds write clears it.
        calcfg_next[RTCPW_B_HALF_SECOND_STATUS] = half_second_in;
        if (wr_calcfg) begin
            if (avs_byteenable[0]) begin
                calcfg_next[RTCPW_W_BYTE-1:0] = avs_writedata[RTCPW_W_BYTE-1:0];
            end
            if (avs_byteenable[1]) begin
                calcfg_next[RTCPW_B_WREN]    = avs_writedata[RTCPW_B_WREN];
                calcfg_next[RTCPW_B_SPARE_A] = avs_writedata[RTCPW_B_SPARE_A];
                calcfg_next[RTCPW_B_SPARE_B] = avs_writedata[RTCPW_B_SPARE_B];
                calcfg_next[RTCPW_B_SPARE_C +: RTCPW_W_SPARE_C] =
                    avs_writedata[RTCPW_B_SPARE_C +: RTCPW_W_SPARE_C];
                // The enable only moves while write-enable is already set.
                if (calcfg_reg[RTCPW_B_WREN]) begin
                    calcfg_next[RTCPW_B_ENABLE] = avs_writedata[RTCPW_B_ENABLE];
                end
            end
        end
        if (wr_pwcfg) begin
            pwcfg_next = avs_writedata[RTCPW_W_REG-1:0] & RTCPW_PWC_MASK;
        end
        if (wr_minutes_seconds_value) begin
            calcfg_next[RTCPW_B_HALF_SECOND_STATUS] = 1'b0;
            presc_rst_next = 1'b1;
        end
    end

    // =========================================================================
    // Clock selection and output pin
    // Both power-line codes pick the same input, so no code leaves timekeeping idle.
    always_comb begin
        case (rtcpw_clk_t'(pwcfg_reg[RTCPW_B_CLK +: RTCPW_W_SEL]))
            RTCPW_CLK_SECONDARY: tick_next = secondary_osc_tick;
            RTCPW_CLK_LOW_POWER_RC_OSC:      tick_next = low_power_rc_osc_tick;
            default:             tick_next = line_tick;
        endcase
    end

    // The unused output code drives low, so the pin never shows a stale source.
    always_comb begin
        pwact_next = pwcfg_reg[RTCPW_B_POWER_CTRL_ENABLE];
        case (pwcfg_reg[RTCPW_B_OUT +: RTCPW_W_SEL])
            RTCPW_OUT_ALARM: pin_next = alarm_pulse;
            RTCPW_OUT_SECS:  pin_next = seconds_clock;
            RTCPW_OUT_PWC:   pin_next = pwc_out;
            default:         pin_next = 1'b0;
        endcase
    end

    // A clear polarity bit inverts the raw request; when disabled the pin rests at its inactive level.
    assign pwc_out = (pwcfg_reg[RTCPW_B_POWER_CTRL_ENABLE] & power_ctrl_raw) ^ ~pwcfg_reg[RTCPW_B_POWER_CTRL_POLARITY];

    // Only the power-on reset reaches these flops.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg     <= RTCPW_ST_IDLE;
            rdata_reg     <= 32'h0000_0000;
            calcfg_reg    <= RTCPW_RST_VAL;
            pwcfg_reg     <= RTCPW_RST_VAL;
            presc_rst_reg <= 1'b0;
            tick_reg      <= 1'b0;
            pin_reg       <= 1'b0;
            pwact_reg     <= 1'b0;
        end else if (clk_en) begin
            state_reg     <= state_next;
            rdata_reg     <= rdata_next;
            calcfg_reg    <= calcfg_next;
            pwcfg_reg     <= pwcfg_next;
            presc_rst_reg <= presc_rst_next;
            tick_reg      <= tick_next;
            pin_reg       <= pin_next;
            pwact_reg     <= pwact_next;
        end
    end

    // =========================================================================
    // Power-control windows
    // Both windows restart with the prescalers, so their phases line up after a seconds write.
    rtcpw_window u_stab (
        .core_clk (core_clk),
        .nrst     (nrst),
        .clk_en   (clk_en),
        .tick_in  (tick_reg),
        .div2     (pwcfg_reg[RTCPW_B_CPRE]),
        .restart  (presc_rst_reg),
        .tick_out (stability_tick)
    );

    rtcpw_window u_samp (
        .core_clk (core_clk),
        .nrst     (nrst),
        .clk_en   (clk_en),
        .tick_in  (tick_reg),
        .div2     (pwcfg_reg[RTCPW_B_SPRE]),
        .restart  (presc_rst_reg),
        .tick_out (sample_tick)
    );

    // =========================================================================
    // Outputs
    assign avs_waitrequest     = (state_reg != RTCPW_ST_DONE);
    assign avs_readdata        = rdata_reg;
    assign timekeeping_tick    = tick_reg;
    assign prescaler_reset     = presc_rst_reg;
    assign clock_module_enable = calcfg_reg[RTCPW_B_ENABLE];
    assign half_second_status  = calcfg_reg[RTCPW_B_HALF_SECOND_STATUS];
    assign power_ctrl_active   = pwact_reg;
    assign clock_out_pin       = pin_reg;
endmodule : rtcpw_ctrl

// *** verification/rtcpw_chk.sv ***
// Purpose: Port checker for rtcpw_ctrl.
// Assumes: A register write has settled once the bus has been quiet for seven cycles.
// Notes:   Mux checks wait for a quiet bus, because the register timing is hidden.
`timescale 1ns/1ps
module rtcpw_chk
    import rtcpw_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        clk_en,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic        secondary_osc_tick,
    input wire logic        low_power_rc_osc_tick,
    input wire logic        line_tick,
    input wire logic        half_second_in,
    input wire logic        alarm_pulse,
    input wire logic        seconds_clock,
    input wire logic        timekeeping_tick,
    input wire logic        prescaler_reset,
    input wire logic        clock_module_enable,
    input wire logic        half_second_status,
    input wire logic        power_ctrl_active,
    input wire logic        clock_out_pin
);
    logic [1:0] tsel_reg, tsel_next, osel_reg, osel_next;
    logic [2:0] quiet_reg, quiet_next;
    always_comb begin
        tsel_next  = tsel_reg;
        osel_next  = osel_reg;
        quiet_next = (quiet_reg == 3'h7) ? quiet_reg : quiet_reg + 3'h1;
        if (avs_write)
            quiet_next = 3'h0;
        if (avs_write && !avs_waitrequest && avs_address == RTCPW_OFS_PWCFG
            && avs_byteenable[1]) begin
            tsel_next = avs_writedata[11:10];
            osel_next = avs_writedata[9:8];
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tsel_reg  <= 2'h0;
            osel_reg  <= 2'h0;
            quiet_reg <= 3'h0;
        end else begin
            tsel_reg  <= tsel_next;
            osel_reg  <= osel_next;
            quiet_reg <= quiet_next;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_rst_clear: assert property (
        $rose(nrst) |-> !power_ctrl_active && !clock_module_enable)
        else $error("config outputs not clear after reset");
    a_enable_cause: assert property (
        $changed(clock_module_enable) |->
            $past(avs_write, 2) && $past(avs_address, 2) == RTCPW_OFS_CALCFG)
        else $error("enable changed without a config write");
    a_pwc_cause: assert property (
        $changed(power_ctrl_active) |->
            $past(avs_write, 2) && $past(avs_address, 2) == RTCPW_OFS_PWCFG)
        else $error("power control changed without a write");
    a_prereset_cause: assert property (
        prescaler_reset |-> $past(avs_write, 2) && $past(avs_address, 2) == RTCPW_OFS_MINSECV
            && $past(avs_byteenable[0], 2))
        else $error("prescaler reset without low-byte write");
    a_prereset_pulse: assert property (
        prescaler_reset |=> !prescaler_reset)
        else $error("prescaler reset longer than one cycle");
    a_half_second_status_rise: assert property (
        $rose(half_second_status) |-> $past(half_second_in))
        else $error("half-second status rose without input");
    a_tick_select: assert property (
        quiet_reg == 3'h7 && $past(clk_en) |-> timekeeping_tick ==
            $past(tsel_reg == 2'h0 ? secondary_osc_tick : (tsel_reg == 2'h1 ? low_power_rc_osc_tick : line_tick)))
        else $error("timekeeping tick from wrong source");
    a_pin_select: assert property (
        quiet_reg == 3'h7 && $past(clk_en) && !osel_reg[1] |->
            clock_out_pin == $past(osel_reg[0] ? seconds_clock : alarm_pulse))
        else $error("output pin from wrong source");
endmodule : rtcpw_chk
bind rtcpw_ctrl rtcpw_chk u_chk (.*);

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for rtcpw_ctrl.
// Assumes: Register reads are checked by a monitor against queued expectations.
// Notes:   Clock enable stays high; freezing is not exercised.
`timescale 1ns/1ps
module tb_top
    import rtcpw_pkg::*;
;
    logic        core_clk, nrst, clk_en, avs_read, avs_write, secondary_osc_tick, low_power_rc_osc_tick, line_tick;
    logic        half_second_in, alarm_pulse, seconds_clock, power_ctrl_raw, avs_waitrequest;
    logic        timekeeping_tick, prescaler_reset, clock_module_enable, half_second_status;
    logic        stability_tick, sample_tick, power_ctrl_active, clock_out_pin, hs_dip, en, e;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [31:0] exp_q[$];
    logic [2:0]  r;
    int          err_count, comparisons, pr_cnt, st_cnt, sa_cnt, i, s, sel;
    integer      seed;
    rtcpw_ctrl uut (.*);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic stop_test();
        if (exp_q.size() != 0)
            err_count++;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // Request held until waitrequest is sampled low, then released.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] v,
                       input logic [3:0] be);
        int n;
        @(posedge core_clk);
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_address    <= a;
        avs_writedata  <= v;
        avs_byteenable <= be;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (n == 20) begin
            err_count++;
            stop_test();
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] v);
        exp_q.push_back(v);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask : rd
    always @(posedge core_clk) begin
        if (avs_read && avs_waitrequest === 1'b0)
            check("readdata", exp_q.pop_front(), avs_readdata);
        if (prescaler_reset === 1'b1)
            pr_cnt++;
        if (stability_tick === 1'b1)
            st_cnt++;
        if (sample_tick === 1'b1)
            sa_cnt++;
        if (half_second_status === 1'b0)
            hs_dip = 1'b1;
    end
    initial begin
        seed = 32'h20CA71DF;
        {nrst, avs_read, avs_write, secondary_osc_tick, low_power_rc_osc_tick, line_tick, half_second_in} = 7'h0;
        {alarm_pulse, seconds_clock, power_ctrl_raw, avs_address, avs_byteenable} = 11'h0;
        {avs_writedata, clk_en} = 33'h1;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        rd(RTCPW_OFS_CALCFG, 32'h0);
        rd(RTCPW_OFS_PWCFG, 32'h0);
        rd(4'hC, 32'h0);
        bus(1'b1, RTCPW_OFS_PWCFG, 32'h00FF, 4'h1);
        rd(RTCPW_OFS_PWCFG, 32'h0);
        d = $random(seed);
        bus(1'b1, RTCPW_OFS_PWCFG, d, 4'h3);
        rd(RTCPW_OFS_PWCFG, d & 32'hFF00);
        bus(1'b1, RTCPW_OFS_CALCFG, 32'h8000, 4'h3);
        rd(RTCPW_OFS_CALCFG, 32'h0);
        bus(1'b1, RTCPW_OFS_CALCFG, 32'h2000, 4'h3);
        bus(1'b1, RTCPW_OFS_CALCFG, 32'hAFFF, 4'h3);
        rd(RTCPW_OFS_CALCFG, 32'hA7FF);
        check("enable", 32'h1, clock_module_enable);
        half_second_in <= 1'b1;
        rd(RTCPW_OFS_CALCFG, 32'hAFFF);
        for (i = 0; i < 2; i++) begin
            {hs_dip, pr_cnt} = 0;
            bus(1'b1, RTCPW_OFS_MINSECV, 32'h0, 4'(2 >> i));
            repeat (4) @(posedge core_clk);
            check("half_clear", 32'(i), hs_dip);
            check("prescaler_reset", 32'(i), pr_cnt);
        end
        half_second_in <= 1'b0;
        for (i = 0; i < 8; i++) begin
            en = $random(seed);
            sel = ((i & 3) > 2) ? 2 : (i & 3);
            bus(1'b1, RTCPW_OFS_PWCFG, {16'h0, en, i[2], 2'h0, i[1:0], 2'(i + 1), 8'h0}, 4'h3);
            // The enable reaches its output flop one edge after the write lands.
            repeat (2) @(posedge core_clk);
            check("power_active", 32'(en), power_ctrl_active);
            for (s = 0; s < 3; s++) begin
                @(posedge core_clk);
                r = $random(seed);
                {secondary_osc_tick, low_power_rc_osc_tick, line_tick} <= 3'(4 >> s);
                {alarm_pulse, seconds_clock, power_ctrl_raw} <= r;
                @(posedge core_clk);
                {secondary_osc_tick, low_power_rc_osc_tick, line_tick} <= 3'h0;
                @(negedge core_clk);
                case ((i + 1) & 3)
                    0: e = r[2];
                    1: e = r[1];
                    2: e = 1'b0;
                    default: e = i[2] ? (en & r[0]) : !(en & r[0]);
                endcase
                check("tick", 32'(s == sel), timekeeping_tick);
                check("pin", 32'(e), clock_out_pin);
            end
        end
        for (i = 0; i < 2; i++) begin
            bus(1'b1, RTCPW_OFS_PWCFG, {16'h0, 2'h3, i[0], !i[0], 4'h4, 8'h0}, 4'h3);
            bus(1'b1, RTCPW_OFS_MINSECV, 32'h0, 4'h1);
            {st_cnt, sa_cnt} = 0;
            repeat (8) begin
                @(posedge core_clk);
                low_power_rc_osc_tick <= 1'b1;
                @(posedge core_clk);
                low_power_rc_osc_tick <= 1'b0;
                repeat (2) @(posedge core_clk);
            end
            repeat (4) @(posedge core_clk);
            check("stability", 32'(8 >> i), st_cnt);
            check("sample", 32'(4 << i), sa_cnt);
        end
        stop_test();
    end
endmodule : tb_top
